// ### ssm_defines.svh
// Constants for the socket status and change-mask register bank.
// Assumes AXI4-Lite with 32-bit data; offsets are byte addresses.
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH

// ============================================================
// Register offsets
`define SSM_OFF_EVENT 8'h00
`define SSM_OFF_MASK 8'h04
`define SSM_OFF_STATE 8'h08
`define SSM_OFF_FORCE 8'h0C

// ============================================================
// Mask field positions
`define SSM_MSK_PWR 3
`define SSM_MSK_CD_HI 2
`define SSM_MSK_CD_LO 1
`define SSM_MSK_STS 0
`define SSM_MSK_W 4

// ============================================================
// Present-state field positions
`define SSM_ST_YSOCK 31
`define SSM_ST_XSOCK 30
`define SSM_ST_LSOCK 29
`define SSM_ST_HSOCK 28
`define SSM_ST_VOLT_HI 13
`define SSM_ST_VOLT_LO 10
`define SSM_ST_BADV 9
`define SSM_ST_LOST 8
`define SSM_ST_NOTC 7
`define SSM_ST_RDY 6
`define SSM_ST_WIDE 5
`define SSM_ST_NARROW 4
`define SSM_ST_PWR 3
`define SSM_ST_CD2 2
`define SSM_ST_CD1 1
`define SSM_ST_STS 0

// ============================================================
// Force-event extras and reset values
`define SSM_FRC_IGNORE 15
`define SSM_FRC_RETEST 14
`define SSM_SOCK_CAP_RST 4'b0011
`define SSM_RESP_OKAY 2'b00
`define SSM_RESP_SLVERR 2'b10

`endif

// ### ssm_pkg.sv
// Types for the socket status and change-mask register bank.
// Assumes ssm_defines.svh is compiled alongside.
package ssm_pkg;
    // Write channel handshake state
    typedef enum logic [1:0] {
        SSM_WR_IDLE = 2'b01,
        SSM_WR_RESP = 2'b10
    } ssm_wr_e;
endpackage

// ### ssm_regs.sv
// Socket status, change-mask and event register bank behind AXI4-Lite.
// Assumes card pins are synchronous to ref_clk_i; interrogation and
// power control live outside and report through strobes and levels.
//
// Behaviour
// - Mask bits 31..4 read zero, writes there are ignored.
// - Mask bit 3 (reset 0) enables interrupt on power-state change.
// - Detect mask field 2..1 resets 00; 11 enables interrupt on any detect-pin change.
// - Mask bit 0 (reset 0) enables interrupt on status-pin change.
// - State bits 31,30 read zero unless forced.
// - State bits 29,28 read one from reset unless forced.
// - State bits 27..14 always read zero.
// - Card voltage and type bits update only at card insertion or a force write.
// - State bit 9 flags an invalid supply request; resets 0.
// - State bit 8 flags possible data loss at removal; resets 0.
// - State bit 7 flags unknown card, held until a valid card or a force write.
// - State bit 6 shows the live ready/interrupt pin level.
// - Bits 5,4 flag wide and narrow cards, change only at interrogation or a force write.
// - State bit 3 reads 1 while socket powered; resets 0.
// - Bits 2,1 follow detect pins, frozen during interrogation.
// - State bit 0 shows the live status pin level.
// - State register read-only; forced values merge with live status.
// - Masks never stop event bits from setting.
// - Event bits set on source change, cleared by write-one or reset.
`timescale 1ns/100ps
`include "ssm_defines.svh"

module ssm_regs (
    input wire logic ref_clk_i, // Host bus clock, 10 MHz
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic detect_pin_one_level_i, // First card-detect pin level
    input wire logic detect_pin_two_level_i, // Second card-detect pin level
    input wire logic status_pin_level_i, // Card status change pin level
    input wire logic ready_irq_pin_level_i, // Card ready/interrupt pin level
    input wire logic socket_powered_i, // Socket power is up
    input wire logic interrogating_i, // Card interrogation in progress
    input wire logic insert_done_i, // Pulse: interrogation finished
    input wire logic [3:0] card_volt_i, // Card voltage support, 13..10 order
    input wire logic wide_card_i, // Interrogation found a 32-bit card
    input wire logic narrow_card_i, // Interrogation found a 16-bit card
    input wire logic unknown_card_i, // Interrogation found no valid card
    input wire logic invalid_supply_req_i, // Pulse: bad supply request
    input wire logic removal_data_loss_i, // Pulse: removal lost data
    input wire logic fault_clear_i, // Pulse: clear supply and loss flags
    output logic retest_o, // Pulse: force re-interrogation
    output logic status_change_irq_o // Card status change interrupt
);

    // ============================================================
    // Write channel: address and data taken in either order
    ssm_pkg::ssm_wr_e wr_state_r;
    logic aw_held_r, w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [3:0] mask_r; // Enables: power, detect pair, status pin
    logic [3:0] event_r; // Sticky change events
    logic [3:0] sock_cap_r; // Socket supply capability 31..28
    logic [3:0] card_volt_r;
    logic bad_supply_r, data_lost_r, not_card_r, wide_r, narrow_r;
    logic cd1_r, cd2_r, pwr_r, sts_r, rdy_r;
    logic [31:0] state_word;

    // Capture each half once it is seen; ready pulses high in the first held cycle only
    wire aw_take = s_axi_awvalid && !aw_held_r && (wr_state_r == ssm_pkg::SSM_WR_IDLE);
    wire w_take = s_axi_wvalid && !w_held_r && (wr_state_r == ssm_pkg::SSM_WR_IDLE);
    wire do_write = aw_held_r && w_held_r && (wr_state_r == ssm_pkg::SSM_WR_IDLE);
    wire wr_mask = do_write && (aw_addr_r == `SSM_OFF_MASK);
    wire wr_event = do_write && (aw_addr_r == `SSM_OFF_EVENT);
    wire wr_force = do_write && (aw_addr_r == `SSM_OFF_FORCE);
    wire wr_state = do_write && (aw_addr_r == `SSM_OFF_STATE);
    wire wr_known = wr_mask || wr_event || wr_force || wr_state;
    // Only the low byte holds writable bits except force bits 14..8 and 31..28
    wire lane0 = w_strb_r[0];
    wire lane1 = w_strb_r[1];
    wire [3:0] ev_clr = (wr_event && lane0) ? w_data_r[3:0] : 4'h0;
    wire [3:0] ev_frc = (wr_force && lane0) ? w_data_r[3:0] : 4'h0;
    wire frc_lo = wr_force && lane0;
    wire frc_hi = wr_force && lane1;

    // Write handshake and mask storage
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_state_r <= ssm_pkg::SSM_WR_IDLE;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSM_RESP_OKAY;
            mask_r <= 4'h0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b1;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            case (wr_state_r)
                ssm_pkg::SSM_WR_IDLE: begin
                    if (do_write) begin
                        // Upper mask bits have no storage, so writes vanish
                        if (wr_mask && lane0) begin
                            mask_r <= w_data_r[`SSM_MSK_W-1:0];
                        end
                        // Present state is read-only; writing it is refused
                        s_axi_bresp <= (wr_known && !wr_state) ? `SSM_RESP_OKAY
                                                               : `SSM_RESP_SLVERR;
                        s_axi_bvalid <= 1'b1;
                        wr_state_r <= ssm_pkg::SSM_WR_RESP;
                    end
                end
                ssm_pkg::SSM_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_held_r <= 1'b0;
                        w_held_r <= 1'b0;
                        wr_state_r <= ssm_pkg::SSM_WR_IDLE;
                    end
                end
                default: wr_state_r <= ssm_pkg::SSM_WR_IDLE;
            endcase
        end
    end
    // Note: awready/wready pulse one cycle after valid, one transfer at a time

    // ============================================================
    // Live pins and change detection
    // Detect pins freeze while interrogation drives them
    wire cd1_nxt = interrogating_i ? cd1_r : detect_pin_one_level_i;
    wire cd2_nxt = interrogating_i ? cd2_r : detect_pin_two_level_i;
    wire [3:0] ev_src = {pwr_r ^ socket_powered_i, cd2_r ^ cd2_nxt,
                         cd1_r ^ cd1_nxt, sts_r ^ status_pin_level_i};

    // Pin images; detect images reset high, the rest low, then follow the pins from the first edge after release
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cd1_r <= 1'b1;
            cd2_r <= 1'b1;
            pwr_r <= 1'b0;
            sts_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            cd1_r <= cd1_nxt;
            cd2_r <= cd2_nxt;
            pwr_r <= socket_powered_i;
            sts_r <= status_pin_level_i;
            rdy_r <= ready_irq_pin_level_i;
        end
    end

    // ============================================================
    // Sticky events: a set in the clearing cycle wins, masks never block
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_event
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    event_r[gi] <= 1'b0;
                end else if (ev_src[gi] || ev_frc[gi]) begin
                    event_r[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin
                    event_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask gating; detect pair uses both field bits so reserved codes stay quiet
    wire cd_en = mask_r[`SSM_MSK_CD_HI] && mask_r[`SSM_MSK_CD_LO];
    wire irq_nxt = (event_r[3] && mask_r[`SSM_MSK_PWR])
                 || ((event_r[2] || event_r[1]) && cd_en)
                 || (event_r[0] && mask_r[`SSM_MSK_STS]);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_change_irq_o <= 1'b0;
        end else begin
            status_change_irq_o <= irq_nxt;
        end
    end

    // ============================================================
    // Card identity and fault flags: insertion results, forces override
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sock_cap_r <= `SSM_SOCK_CAP_RST;
            card_volt_r <= 4'h0;
            wide_r <= 1'b0;
            narrow_r <= 1'b0;
            not_card_r <= 1'b0;
            bad_supply_r <= 1'b0;
            data_lost_r <= 1'b0;
            retest_o <= 1'b0;
        end else begin
            retest_o <= frc_hi && w_data_r[`SSM_FRC_RETEST];
            if (insert_done_i) begin
                card_volt_r <= card_volt_i;
                wide_r <= wide_card_i;
                narrow_r <= narrow_card_i;
                // At insertion the unknown flag only drops when a valid card arrives
                if (unknown_card_i) begin
                    not_card_r <= 1'b1;
                end else if (wide_card_i || narrow_card_i) begin
                    not_card_r <= 1'b0;
                end
            end
            if (invalid_supply_req_i) begin
                bad_supply_r <= 1'b1;
            end else if (fault_clear_i) begin
                bad_supply_r <= 1'b0;
            end
            if (removal_data_loss_i) begin
                data_lost_r <= 1'b1;
            end else if (fault_clear_i) begin
                data_lost_r <= 1'b0;
            end
            // Forced writes land in the state fields alongside live status
            if (frc_hi) begin
                card_volt_r <= w_data_r[`SSM_ST_VOLT_HI:`SSM_ST_VOLT_LO];
                bad_supply_r <= w_data_r[`SSM_ST_BADV];
                data_lost_r <= w_data_r[`SSM_ST_LOST];
            end
            if (frc_lo) begin
                not_card_r <= w_data_r[`SSM_ST_NOTC];
                wide_r <= w_data_r[`SSM_ST_WIDE];
                narrow_r <= w_data_r[`SSM_ST_NARROW];
            end
            // Socket capability override through the force top byte
            if (wr_force && w_strb_r[3]) begin
                sock_cap_r <= w_data_r[`SSM_ST_YSOCK:`SSM_ST_HSOCK];
            end
        end
    end

    // ============================================================
    // Present-state word; bits 27..14 have no storage and read zero
    assign state_word = {sock_cap_r, 14'h0000, card_volt_r,
                         bad_supply_r, data_lost_r, not_card_r, rdy_r,
                         wide_r, narrow_r, pwr_r, cd2_r, cd1_r, sts_r};

    // Read decode; force register is write-only and reads zero
    wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
    wire rd_hit = (ar_word == `SSM_OFF_EVENT) || (ar_word == `SSM_OFF_MASK)
                  || (ar_word == `SSM_OFF_STATE) || (ar_word == `SSM_OFF_FORCE);
    wire [31:0] rd_mux = (ar_word == `SSM_OFF_EVENT) ? {28'h000_0000, event_r}
                       : (ar_word == `SSM_OFF_MASK) ? {28'h000_0000, mask_r}
                       : (ar_word == `SSM_OFF_STATE) ? state_word
                       : 32'h0000_0000;
    wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    // Read channel: one read in flight, data one cycle after address
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SSM_RESP_OKAY;
        end else begin
            s_axi_arready <= ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // ssm_regs

// ### ssm_regs_sva.sv
// Checker for the socket status register bank: bus timing and fixed fields.
// Assumes it is bound to ssm_regs and sees only its ports.
`timescale 1ns/100ps
`include "ssm_defines.svh"

// ============================================================
// Checker
module ssm_regs_sva (
    input wire logic ref_clk_i, // Bus clock
    input wire logic srst_i, // Sync reset
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wready, // Write data ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic status_change_irq_o // Status change interrupt
);
    logic [7:0] ra_r;
    logic [7:0] wa_r;
    logic ar_take;
    logic ra_mapped;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Read is taken only while idle; the address is kept to judge the data
    assign ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign ra_mapped = (ra_r[7:4] == 4'h0) && (ra_r[1:0] == 2'b00);
    always_ff @(posedge ref_clk_i) begin
        if (ar_take) ra_r <= s_axi_araddr;
        if (s_axi_awready) wa_r <= s_axi_awaddr;
    end
    property p_wr_resp; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write response not released");
    property p_rd; ar_take |=> s_axi_arready && s_axi_rvalid ##1 !s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer timing wrong");
    property p_rd_err;
        s_axi_rvalid && !ra_mapped |-> s_axi_rresp == `SSM_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_mask_rsvd;
        s_axi_rvalid && ra_r == `SSM_OFF_MASK |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask upper bits set");
    property p_state_rsvd;
        s_axi_rvalid && ra_r == `SSM_OFF_STATE |-> s_axi_rdata[27:14] == 14'h0;
    endproperty
    a_state_rsvd: assert property (p_state_rsvd) else $error("state gap bits set");
    property p_state_wr;
        s_axi_bvalid && wa_r == `SSM_OFF_STATE |-> s_axi_bresp == `SSM_RESP_SLVERR;
    endproperty
    a_state_wr: assert property (p_state_wr) else $error("state write accepted");
    property p_rst;
        $fell(srst_i) |-> !status_change_irq_o && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
    c_wr: cover property (s_axi_awready && s_axi_wready);
    c_rd: cover property (ar_take);
    c_irq: cover property ($rose(status_change_irq_o));
endmodule // ssm_regs_sva

bind ssm_regs ssm_regs_sva i_sva (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .status_change_irq_o(status_change_irq_o));

// ### ssm_card_model.sv
// Card model at the socket: seats a card and runs an interrogation.
// Assumes insert_i is a one-cycle pulse on the bus clock.
`timescale 1ns/100ps

// ============================================================
// Card model
module ssm_card_model (
    input wire logic ref_clk_i, // Bus clock
    input wire logic srst_i, // Sync reset, active high
    input wire logic insert_i, // Pulse: seat a new card
    input wire logic [5:0] kind_i, // Volts 3..0, wide, narrow
    output logic cd1_o, // First detect pin, high = empty
    output logic cd2_o, // Second detect pin, high = empty
    output logic busy_o, // Interrogation running
    output logic done_o, // Pulse: interrogation over
    output logic [3:0] volt_o, // Card voltage support
    output logic wide_o, // Wide card found
    output logic narrow_o, // Narrow card found
    output logic unk_o // No valid card found
);
    logic [3:0] cnt_r;
    // Results follow kind_i live, so a latch that ignores done shows up
    assign volt_o = kind_i[5:2];
    assign wide_o = kind_i[1];
    assign narrow_o = kind_i[0];
    assign unk_o = ~|kind_i[1:0];
    assign busy_o = (cnt_r != 4'h0);
    // Pins drop at insertion; cd2 chatters during the probe, ending low
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_r <= 4'h0;
            cd1_o <= 1'b1;
            cd2_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_r == 4'h1);
            if (insert_i) begin
                cnt_r <= 4'hC;
                cd1_o <= 1'b0;
                cd2_o <= 1'b0;
            end else if (busy_o) begin
                cnt_r <= cnt_r - 4'h1;
                cd2_o <= ~cd2_o;
            end
        end
    end
endmodule // ssm_card_model

// ### ssm_regs_bench.sv
// Self-checking bench for the socket status register bank.
// Assumes ssm_regs, its checker and the card model are compiled first.
`timescale 1ns/100ps
`include "ssm_defines.svh"

// ============================================================
// Bench
module ssm_regs_bench;
    logic clk, rst = 1'b1, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, retest, irq, rt_seen = 0;
    logic sts = 0, rdy = 0, pwr = 0, bad = 0, lost = 0, fclr = 0, ins = 0;
    logic [5:0] kind = 0;
    logic cd1, cd2, busy, done, wide, narrow, unk;
    logic [3:0] cvolt;
    int mismatches = 0, compares = 0;

    ssm_regs i_dut (.ref_clk_i(clk), .srst_i(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .detect_pin_one_level_i(cd1), .detect_pin_two_level_i(cd2), .status_pin_level_i(sts),
        .ready_irq_pin_level_i(rdy), .socket_powered_i(pwr), .interrogating_i(busy),
        .insert_done_i(done), .card_volt_i(cvolt), .wide_card_i(wide), .narrow_card_i(narrow),
        .unknown_card_i(unk), .invalid_supply_req_i(bad), .removal_data_loss_i(lost),
        .fault_clear_i(fclr), .retest_o(retest), .status_change_irq_o(irq));
    ssm_card_model i_card (.ref_clk_i(clk), .srst_i(rst), .insert_i(ins), .kind_i(kind),
        .cd1_o(cd1), .cd2_o(cd2), .busy_o(busy), .done_o(done), .volt_o(cvolt),
        .wide_o(wide), .narrow_o(narrow), .unk_o(unk));

    // Clock, and a sticky flag because the retest pulse lasts one cycle
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (retest) rt_seen <= 1'b1;

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask
    // Bus write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        if (n >= 50) tmo();
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // Bus read and compare; the extra edge keeps arvalid drives apart
    task automatic rc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        if (n >= 50) tmo();
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask
    task automatic seat(input logic [5:0] k);
        int n;
        kind <= k;
        ins <= 1'b1;
        @(posedge clk);
        ins <= 1'b0;
        for (n = 0; n < 40 && !done; n++) @(posedge clk);
        if (!done) tmo();
        repeat (3) @(posedge clk);
    endtask

    // Reset values, reserved bits and refused accesses
    task automatic t_basic;
        rc(`SSM_OFF_MASK, 32'h0, `SSM_RESP_OKAY);
        rc(`SSM_OFF_STATE, 32'h3000_0006, `SSM_RESP_OKAY);
        wr(`SSM_OFF_MASK, 32'hFFFF_FFF5, 4'hF, `SSM_RESP_OKAY);
        rc(`SSM_OFF_MASK, 32'h0000_0005, `SSM_RESP_OKAY);
        wr(`SSM_OFF_STATE, 32'hFFFF_FFFF, 4'hF, `SSM_RESP_SLVERR);
        rc(`SSM_OFF_STATE, 32'h3000_0006, `SSM_RESP_OKAY);
        rc(8'h20, 32'h0, `SSM_RESP_SLVERR);
    endtask
    // Nine mask settings against forced events; events set whatever the mask
    task automatic t_irq;
        logic [3:0] tm[9] = '{4'h0, 4'h8, 4'h8, 4'h1, 4'h1, 4'h6, 4'h2, 4'h4, 4'hE};
        logic [3:0] tf[9] = '{4'hF, 4'h8, 4'h7, 4'h1, 4'hE, 4'h6, 4'h6, 4'h6, 4'h1};
        logic te[9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 9; i++) begin
            wr(`SSM_OFF_EVENT, 32'h0000_000F, 4'hF, `SSM_RESP_OKAY);
            wr(`SSM_OFF_MASK, {28'h0, tm[i]}, 4'hF, `SSM_RESP_OKAY);
            wr(`SSM_OFF_FORCE, {28'h0, tf[i]}, 4'h1, `SSM_RESP_OKAY);
            repeat (3) @(posedge clk);
            chk({31'h0, irq}, {31'h0, te[i]});
            rc(`SSM_OFF_EVENT, {28'h0, tf[i]}, `SSM_RESP_OKAY);
        end
        wr(`SSM_OFF_EVENT, 32'h0000_000F, 4'hF, `SSM_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Live pins and fault pulses reach the state register
    task automatic t_pins;
        sts <= 1'b1;
        rdy <= 1'b1;
        pwr <= 1'b1;
        bad <= 1'b1;
        lost <= 1'b1;
        @(posedge clk);
        bad <= 1'b0;
        lost <= 1'b0;
        repeat (3) @(posedge clk);
        rc(`SSM_OFF_STATE, 32'h3000_034F, `SSM_RESP_OKAY);
        rc(`SSM_OFF_EVENT, 32'h0000_0009, `SSM_RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        fclr <= 1'b1;
        {sts, rdy, pwr} <= 3'b000;
        @(posedge clk);
        fclr <= 1'b0;
        repeat (3) @(posedge clk);
        rc(`SSM_OFF_STATE, 32'h3000_0006, `SSM_RESP_OKAY);
        wr(`SSM_OFF_EVENT, 32'h0000_000F, 4'hF, `SSM_RESP_OKAY);
    endtask
    // Insertions: frozen detect bits, latched card fields, forced caps
    task automatic t_card;
        kind <= 6'b1010_10;
        ins <= 1'b1;
        @(posedge clk);
        ins <= 1'b0;
        rc(`SSM_OFF_STATE, 32'h3000_0006, `SSM_RESP_OKAY);
        seat(6'b1010_10);
        rc(`SSM_OFF_STATE, 32'h3000_2820, `SSM_RESP_OKAY);
        kind <= 6'b0101_01;
        repeat (3) @(posedge clk);
        rc(`SSM_OFF_STATE, 32'h3000_2820, `SSM_RESP_OKAY);
        seat(6'b0000_00);
        rc(`SSM_OFF_STATE, 32'h3000_0080, `SSM_RESP_OKAY);
        seat(6'b0001_01);
        rc(`SSM_OFF_STATE, 32'h3000_0410, `SSM_RESP_OKAY);
        wr(`SSM_OFF_FORCE, 32'hC000_4000, 4'hA, `SSM_RESP_OKAY);
        repeat (3) @(posedge clk);
        rc(`SSM_OFF_STATE, 32'hC000_0010, `SSM_RESP_OKAY);
        chk({31'h0, rt_seen}, 32'h1);
    endtask

    // Main sequence: reset for five cycles, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_basic();
        t_irq();
        t_pins();
        t_card();
        wrap_up();
    end
endmodule // ssm_regs_bench
